// ### hw/sbs_pkg.sv
package sbs_pkg;
    // Array shape
    localparam int ADDR_W     = 17;
    localparam int DATA_W     = 36;
    localparam int LANES      = 4;
    localparam int LANE_W     = 9;
    localparam int DEPTH      = 131072;
    // Burst counter
    localparam int BURST_W    = 2;
    localparam logic [1:0] BURST_ONE  = 2'h1;
    localparam logic [1:0] BURST_LAST = 2'h3;
    localparam logic [1:0] BURST_ZERO = 2'h0;
    // Data buffer and byte-lane masks
    localparam int BUF_DEPTH  = 2;
    localparam logic [3:0] LANES_ALL  = 4'hf;
    localparam logic [3:0] LANES_NONE = 4'h0;
    // Configuration set-up time (bus master side), slow grade
    localparam int CFG_SETUP_NS  = 30;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CFG_SETUP_CYC =
        (CFG_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ### hw/sbs_buf.sv
`timescale 1ns/1ps
// Two-entry FIFO; output data always comes from a flip-flop
module sbs_buf #(
    parameter int WIDTH = 36
) (
    // Clock and reset
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst_n,
    // Fill side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // Drain side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    import sbs_pkg::*;

    logic [WIDTH-1:0] ent_reg [BUF_DEPTH];
    logic [WIDTH-1:0] ent_next [BUF_DEPTH];
    logic             wp_reg;
    logic             wp_next;
    logic             rp_reg;
    logic             rp_next;
    logic [1:0]       cnt_reg;
    logic [1:0]       cnt_next;
    logic             push;
    logic             pop;

    assign o_in_ready  = (cnt_reg != 2'h2);
    assign o_out_valid = (cnt_reg != 2'h0);
    assign o_out_data  = ent_reg[rp_reg];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_comb begin
        ent_next = ent_reg;
        wp_next  = wp_reg;
        rp_next  = rp_reg;
        cnt_next = cnt_reg;
        if (push) begin
            ent_next[wp_reg] = i_in_data;
            wp_next          = ~wp_reg;
        end
        if (pop) begin
            rp_next = ~rp_reg;
        end
        if (push && !pop) begin
            cnt_next = cnt_reg + 2'h1;
        end else if (pop && !push) begin
            cnt_next = cnt_reg - 2'h1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        ent_reg <= ent_next;
        if (!i_rst_n) begin
            wp_reg  <= 1'b0;
            rp_reg  <= 1'b0;
            cnt_reg <= 2'h0;
        end else begin
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
        end
    end

    no_overfill_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (cnt_reg == 2'h2 && !pop) |=> cnt_reg == 2'h2)
        else $error("buffer count changed while full and stalled");
endmodule

// ### hw/sbs_port.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Function
// [R1] Master holds burst order static before use
// [R2] Master keeps device deselected after power-up
// [R3] Master sends deselects when leaving sleep
// [R4] Sleep drops burst; master restarts externally
// [R5] Sleep low for all normal cycles
// [R6] Burst advances only two low bits
// [R7] Step high suspends counter, word repeats
// [R8] Either strobe starts a read alike
// [R9] Gate plus all lanes equals global write
// [R10] Select needs both lows low, high high
// [R11] Master keeps output enable high on writes
// [R12] Interleaved order: start XOR count
// [R13] Linear order: start plus count, wraps
// [R14] Global writes all, else chosen lanes
// [R15] Output enable asynchronous; float otherwise
// [R16] Read data one edge after address
module sbs_port (
    // Clock and reset
    input  wire logic                        i_clk_sys,
    input  wire logic                        i_rst_n,
    // Address and selects
    input  wire logic [sbs_pkg::ADDR_W-1:0]  i_addr,
    input  wire logic                        i_chip_en_n,
    input  wire logic                        i_select_high,
    input  wire logic                        i_select_low_n,
    // Strobes and burst control
    input  wire logic                        i_processor_address_strobe_n,
    input  wire logic                        i_controller_address_strobe_n,
    input  wire logic                        i_burst_step_n,
    input  wire logic                        i_burst_order_select,
    input  wire logic                        i_sleep_request,
    // Write control
    input  wire logic                        i_global_write_n,
    input  wire logic                        i_byte_write_gate_n,
    input  wire logic [sbs_pkg::LANES-1:0]   i_byte_lane_write_n,
    input  wire logic [sbs_pkg::DATA_W-1:0]  i_dq_in,
    // Read data
    input  wire logic                        i_output_enable_n,
    input  wire logic                        i_rd_ready,
    output logic                             o_rd_valid,
    output logic                             o_accept_ready,
    output logic [sbs_pkg::DATA_W-1:0]       o_dq_out,
    output logic                             o_dq_oe
);
    import sbs_pkg::*;

    logic [DATA_W-1:0]  mem [DEPTH];
    logic [ADDR_W-1:0]  base_reg;
    logic [ADDR_W-1:0]  base_next;
    logic [BURST_W-1:0] cnt_reg;
    logic [BURST_W-1:0] cnt_next;
    logic               active_reg;
    logic               active_next;
    logic               selected;
    logic               strobe;
    logic               start;
    logic               step;
    logic               access;
    logic               wr_en;
    logic [LANES-1:0]   lane_we;
    logic [ADDR_W-1:0]  acc_addr;
    logic [DATA_W-1:0]  rd_word;
    logic               rd_push;

    //////////////////////////////////////////////////////////////////////////
    // Cycle decode

    function automatic logic [BURST_W-1:0] seq_bits(
        input logic [BURST_W-1:0] first,
        input logic [BURST_W-1:0] count,
        input logic               interleave
    );
        if (interleave) begin
            seq_bits = first ^ count; // [R12]
        end else begin
            seq_bits = first + count; // [R13]
        end
    endfunction

    assign selected = !i_chip_en_n && !i_select_low_n &&
                      i_select_high; // [R10]
    assign strobe   = !i_processor_address_strobe_n ||
                      !i_controller_address_strobe_n; // [R8]
    assign start    = strobe && selected && !i_sleep_request;
    assign step     = active_reg && !strobe && !i_burst_step_n
                      && !i_sleep_request;
    assign access   = start ||
                      (active_reg && !strobe && !i_sleep_request);

    // A start through the processor strobe is always a read; writes need
    // the controller strobe or a following cycle.
    assign wr_en = access &&
                   !(start && !i_processor_address_strobe_n) &&
                   (!i_global_write_n ||
                    (!i_byte_write_gate_n &&
                     (i_byte_lane_write_n != LANES_ALL))); // [R14]
    assign lane_we = !wr_en ? LANES_NONE :
                     !i_global_write_n ? LANES_ALL : // [R9]
                     ~i_byte_lane_write_n; // [R14]

    //////////////////////////////////////////////////////////////////////////
    // Burst counter

    always_comb begin
        base_next   = base_reg;
        cnt_next    = cnt_reg;
        active_next = active_reg;
        if (i_sleep_request) begin
            // Address and count registers hold through power-down; only the burst flag drops
            active_next = 1'b0; // [R4]
        end else if (strobe && !selected) begin
            active_next = 1'b0; // [R10]
        end else if (start) begin
            base_next   = i_addr;
            cnt_next    = BURST_ZERO;
            active_next = 1'b1;
        end else if (step) begin
            cnt_next = cnt_reg + BURST_ONE; // [R6] [R13]
        end
        // Otherwise a suspended burst holds the count
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            base_reg   <= '0;
            cnt_reg    <= BURST_ZERO;
            active_reg <= 1'b0;
        end else begin
            base_reg   <= base_next;
            cnt_reg    <= cnt_next; // [R7]
            active_reg <= active_next;
        end
    end

    // Upper bits from the base after the start cycle; only the low pair follows the order
    assign acc_addr = start ? i_addr :
        {base_reg[ADDR_W-1:BURST_W],
         seq_bits(base_reg[BURST_W-1:0], cnt_next,
                  i_burst_order_select)}; // [R6]

    //////////////////////////////////////////////////////////////////////////
    // Array and read path

    always_ff @(posedge i_clk_sys) begin
        for (int l = 0; l < LANES; l++) begin
            if (lane_we[l]) begin
                mem[acc_addr][l*LANE_W +: LANE_W] <=
                    i_dq_in[l*LANE_W +: LANE_W];
            end
        end
    end

    assign rd_word = mem[acc_addr];
    assign rd_push = access && !wr_en;

    // A stalled receiver fills the buffer; the master must stop issuing
    // reads while the accept ready is low.
    sbs_buf #(
        .WIDTH(DATA_W)
    ) u_rd_buf (
        .i_clk_sys  (i_clk_sys),
        .i_rst_n    (i_rst_n),
        .i_in_valid (rd_push),
        .o_in_ready (o_accept_ready),
        .i_in_data  (rd_word),
        .o_out_valid(o_rd_valid),
        .i_out_ready(i_rd_ready),
        .o_out_data (o_dq_out) // [R16]
    );

    // Output enable is not registered so the pins follow it at once
    assign o_dq_oe = o_rd_valid && !i_output_enable_n
                     && !i_sleep_request; // [R15]

    //////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    step_adv_a: assert property ( // [R6]
        step |=> cnt_reg == $past(cnt_reg) + BURST_ONE
                 && base_reg == $past(base_reg))
        else $error("burst count did not step by one");

    suspend_hold_a: assert property ( // [R7]
        (active_reg && !strobe && i_burst_step_n && !i_sleep_request)
        |=> cnt_reg == $past(cnt_reg) && active_reg)
        else $error("suspended burst moved its count");

    // Second word measured against the start address, not the counter
    ilv_order_a: assert property ( // [R12]
        (start && i_burst_order_select) ##1 step
        |-> acc_addr == {$past(i_addr[ADDR_W-1:BURST_W]),
                         $past(i_addr[BURST_W-1:0]) ^ BURST_ONE})
        else $error("interleaved address wrong");

    lin_order_a: assert property ( // [R13]
        (start && !i_burst_order_select) ##1 step
        |-> acc_addr == {$past(i_addr[ADDR_W-1:BURST_W]),
                         2'($past(i_addr[BURST_W-1:0]) + BURST_ONE)})
        else $error("linear address wrong");

    lin_wrap_a: assert property ( // [R13]
        (step && cnt_reg == BURST_LAST) |=> cnt_reg == BURST_ZERO)
        else $error("linear burst did not wrap");

    strobe_load_a: assert property ( // [R8]
        start |=> active_reg && base_reg == $past(i_addr)
                  && cnt_reg == BURST_ZERO)
        else $error("strobe did not load address");

    deselect_a: assert property ( // [R10]
        (strobe && !selected) |=> !active_reg)
        else $error("deselect left burst active");

    lane_map_a: assert property ( // [R14]
        (wr_en && i_global_write_n) |-> lane_we == ~i_byte_lane_write_n)
        else $error("byte lanes mis-mapped");

    global_all_a: assert property ( // [R9]
        (wr_en && !i_global_write_n) |-> lane_we == LANES_ALL)
        else $error("global write missed lanes");

    float_out_a: assert property ( // [R15]
        (i_output_enable_n || i_sleep_request || !o_rd_valid) |-> !o_dq_oe)
        else $error("data driven while disabled");

    sleep_drop_a: assert property ( // [R4]
        i_sleep_request |=> !active_reg ##0 !step)
        else $error("burst survived sleep");

    rd_latency_a: assert property ( // [R16]
        (rd_push && !o_rd_valid) |=> o_rd_valid && o_dq_out == $past(rd_word))
        else $error("read data not one edge after address");

    burst_cov: cover property (start ##1 step[*3]);
    suspend_cov: cover property (step ##1 (active_reg && i_burst_step_n
                                 && !strobe) ##1 step);
    stall_cov: cover property (!o_accept_ready);
    write_cov: cover property (wr_en && i_global_write_n);
endmodule

// ### tb/sbs_sink.sv
`timescale 1ns/1ps
// Read-data receiver on the master side; can stall on demand
module sbs_sink
    import sbs_pkg::*;
(
    // Clock and control
    input  wire logic              i_clk_sys,
    input  wire logic              i_stall,
    // Read data from the port
    input  wire logic              i_valid,
    input  wire logic [DATA_W-1:0] i_data,
    output logic                   o_ready
);
    logic [DATA_W-1:0] q[$];

    assign o_ready = !i_stall;
    // Word handed over only on valid and ready in the same edge
    always @(posedge i_clk_sys) begin
        if (i_valid && o_ready) begin
            q.push_back(i_data);
        end
    end
endmodule

// ### tb/sync_burst_sram_port_test.sv
`timescale 1ns/1ps
module sync_burst_sram_port_test;
    import sbs_pkg::*;
    logic              clk, rst_n, ce_n, sh, sl_n, ps_n, cs_n, st_n, burst_order_select;
    logic              zz, gw_n, bg_n, oe_n, stall, rv, ar, oe, rdy;
    logic [ADDR_W-1:0] a;
    logic [LANES-1:0]  bl_n;
    logic [DATA_W-1:0] d, dq;
    int                n_mismatch, tests_run;
    int                ks[6] = '{0, 1, 1, 2, 3, 0};
    // Row: order select, processor strobe, base address
    logic [18:0]       rows[4] = '{{2'b01, 17'h00101}, {2'b10, 17'h1fff2},
                                   {2'b11, 17'h00043}, {2'b00, 17'h00aa3}};

    sbs_port sbs_port_inst (.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(a),
        .i_chip_en_n(ce_n), .i_select_high(sh), .i_select_low_n(sl_n),
        .i_processor_address_strobe_n(ps_n),
        .i_controller_address_strobe_n(cs_n), .i_burst_step_n(st_n),
        .i_burst_order_select(burst_order_select), .i_sleep_request(zz),
        .i_global_write_n(gw_n), .i_byte_write_gate_n(bg_n),
        .i_byte_lane_write_n(bl_n), .i_dq_in(d), .i_output_enable_n(oe_n),
        .i_rd_ready(rdy), .o_rd_valid(rv), .o_accept_ready(ar),
        .o_dq_out(dq), .o_dq_oe(oe));
    sbs_sink sbs_sink_inst (.i_clk_sys(clk), .i_stall(stall), .i_valid(rv),
        .i_data(dq), .o_ready(rdy));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    //////////////////////////////////////////////////////////////////////
    // Kinds: 0 deselect, 1/2 read by either strobe, 3 global write,
    // 4 lane write, 5 step, 6 suspend, 7 sleep, 8 select pair dropped,
    // 9 global write offered with the processor strobe (a read)
    task automatic drv(input int k, input logic [16:0] aa = '0,
                       input logic [35:0] dd = '0,
                       input logic [3:0] ln = 4'hf);
        ps_n <= !(k == 1 || k == 9);
        cs_n <= !(k inside {0, 2, 3, 4, 8});
        ce_n <= (k == 0);
        // High select always moves opposite to the low select
        sh   <= !(k == 0 || k == 8);
        sl_n <= (k == 0 || k == 8);
        gw_n <= !(k == 3 || k == 9);
        bg_n <= !(k == 4);
        bl_n <= ln;
        st_n <= !(k == 5);
        zz   <= (k == 7);
        oe_n <= (k == 3 || k == 4);
        a    <= aa;
        d    <= dd;
        @(posedge clk);
    endtask

    task automatic chk(input logic [35:0] g, input logic [35:0] e);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic expect_q(input logic [35:0] e);
        if (sbs_sink_inst.q.size() == 0) chk('x, e);
        else chk(sbs_sink_inst.q.pop_front(), e);
    endtask

    function automatic logic [35:0] pat(input int r, input logic [16:0] aa);
        return {4'(r + 1), 15'h0, aa};
    endfunction

    function automatic logic [16:0] ba(input logic [16:0] b, input logic il,
                                       input int k);
        return {b[16:2], il ? b[1:0] ^ 2'(k) : b[1:0] + 2'(k)};
    endfunction

    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Bounded run; a hang counts as a mismatch
    initial begin
        #500000;
        n_mismatch++;
        report_and_stop;
    end

    //////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, ce_n, sh, sl_n, ps_n, cs_n, st_n} = 7'h2d;
        {burst_order_select, zz, gw_n, bg_n, oe_n, stall} = 6'h1c;
        bl_n = 4'hf;
        a = '0;
        d = '0;
        n_mismatch = 0;
        tests_run = 0;
        @(posedge clk);
        for (int r = 0; r < 4; r++) begin
            burst_order_select <= rows[r][18];
            rst_n <= 1'b0;
            repeat (8) drv(0);
            rst_n <= 1'b1;
            drv(0);
            #1 chk(36'({rv, oe, ar}), 36'h1);
            for (int k = 0; k < 4; k++) begin
                drv(3, ba(rows[r][16:0], 1'b0, k),
                    pat(r, ba(rows[r][16:0], 1'b0, k)));
            end
            drv(rows[r][17] ? 1 : 2, rows[r][16:0]);
            drv(5);
            drv(6);
            drv(5);
            drv(5);
            drv(5);
            repeat (4) drv(0);
            foreach (ks[i])
                expect_q(pat(r, ba(rows[r][16:0], rows[r][18],
                                   ks[i])));
            chk(36'(sbs_sink_inst.q.size()), 36'h0);
        end
        $display("test burst rows done");

        drv(3, 17'h00200, 36'h0);
        drv(4, 17'h00200, '1, 4'b1010);
        drv(2, 17'h00200, '1, 4'h0);
        drv(4, 17'h00204, 36'h123456789, 4'h0);
        drv(1, 17'h00204);
        drv(9, 17'h00204, 36'h0);
        drv(2, 17'h00204);
        repeat (3) drv(0);
        expect_q(36'h007fc01ff);
        expect_q(36'h123456789);
        expect_q(36'h123456789);
        expect_q(36'h123456789);
        $display("test lane writes done");

        stall <= 1'b1;
        drv(2, 17'h00aa3);
        drv(5);
        drv(5);
        // Burst still live here so that sleep has something to drop
        drv(6);
        #1 chk(36'({rv, oe, ar}), 36'h6);
        drv(7);
        #1 chk(36'(oe), 36'h0);
        drv(0);
        drv(0);
        stall <= 1'b0;
        drv(5);
        drv(8, 17'h00aa3);
        drv(5);
        repeat (3) drv(0);
        expect_q(pat(3, 17'h00aa3));
        expect_q(pat(3, 17'h00aa0));
        chk(36'(sbs_sink_inst.q.size()), 36'h0);
        $display("test stall sleep deselect done");
        report_and_stop;
    end
endmodule
